// ### crf_pkg.sv
// Purpose: Shared constants and types for the CPU register file and flags block.
// Assumes: One system clock, asynchronous active-low reset.
// Notes:   Flag bit positions, access sizes and address modes live here.
package crf_pkg;

   localparam int GP_COUNT   = 8;
   localparam int GP_WIDTH   = 32;
   localparam int PC_WIDTH   = 24;
   localparam int FLAG_WIDTH = 8;
   localparam int SEL_WIDTH  = 3;

   localparam int FLAG_IMASK = 7;
   localparam int FLAG_UMASK = 6;
   localparam int FLAG_HALF  = 5;
   localparam int FLAG_USER  = 4;
   localparam int FLAG_NEG   = 3;
   localparam int FLAG_ZERO  = 2;
   localparam int FLAG_OVF   = 1;
   localparam int FLAG_CARRY = 0;

   localparam int STACK_SEL = 7;

   localparam logic [FLAG_WIDTH-1:0] FLAGS_RESET = 8'h80;
   localparam logic [PC_WIDTH-1:0]   PC_RESET    = 24'h000000;

   localparam logic [PC_WIDTH-1:0] MASK_NORMAL = 24'h00ffff;
   localparam logic [PC_WIDTH-1:0] MASK_1MB    = 24'h0fffff;
   localparam logic [PC_WIDTH-1:0] MASK_16MB   = 24'hffffff;

   typedef enum logic [1:0] {
      SZ_BYTE_LO,
      SZ_BYTE_HI,
      SZ_WORD,
      SZ_LONG
   } crf_size_type;

   typedef enum logic [1:0] {
      AM_NORMAL,
      AM_1MB,
      AM_16MB,
      AM_RSVD
   } crf_amode_type;

   typedef enum logic [2:0] {
      FOP_NONE,
      FOP_ARITH,
      FOP_LOGIC,
      FOP_LOAD,
      FOP_AND,
      FOP_OR,
      FOP_XOR,
      FOP_CARRY
   } crf_fop_type;

   typedef struct packed {
      logic                 en;
      logic [SEL_WIDTH-1:0] sel;
      logic                 ext_half;
      crf_size_type         size;
      logic [GP_WIDTH-1:0]  data;
   } crf_gp_wr_type;

   typedef struct packed {
      crf_fop_type          op;
      crf_size_type         size;
      logic [GP_WIDTH-1:0]  a;
      logic [GP_WIDTH-1:0]  b;
      logic [GP_WIDTH-1:0]  result;
      logic                 sub;
      logic                 has_half;
      logic                 ovf;
      logic                 carry;
      logic [FLAG_WIDTH-1:0] imm;
   } crf_flag_upd_type;

endpackage

// ### crf_addr_unit.sv
// Purpose: Effective-address shaping for the register file block.
// Assumes: Combinational inputs from the same clock domain.
// Notes:   Output registered so the top sees a flop-driven address.
`timescale 1ns/1ps
`default_nettype none
module crf_addr_unit
   import crf_pkg::*;
(
   // Clock and reset.
   input  wire logic                clk_sys,
   input  wire logic                resetn,
   // Request.
   input  wire logic [GP_WIDTH-1:0] addr_in,
   input  wire crf_amode_type       amode,
   input  wire logic                wide_access,
   // Result.
   output logic [PC_WIDTH-1:0]      addr_out
);

   logic [PC_WIDTH-1:0] mask;
   logic [PC_WIDTH-1:0] shaped;

   always_comb begin
      unique case (amode)
         AM_NORMAL: mask = MASK_NORMAL;
         AM_1MB:    mask = MASK_1MB;
         default:   mask = MASK_16MB;
      endcase
      shaped = addr_in[PC_WIDTH-1:0] & mask;
      // Odd word or longword addresses are silently rounded down, never trapped.
      if (wide_access) begin
         shaped[0] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         addr_out <= '0;
      end else begin
         addr_out <= shaped;
      end
   end

endmodule
`default_nettype wire

// ### crf_core.sv
// Purpose: Programmer-visible general registers, program counter and condition flags.
// Assumes: Decoder and ALU drive requests on clk_sys; reset vector is supplied by them.
// Notes:   General registers have no reset so that software must set the stack itself.
//
// Behaviour
// - Eight alike 32-bit general registers, full-width readable and writable.
// - Each register splits into independent upper and lower 16-bit halves.
// - Each lower half splits into high and low bytes.
// - Register seven doubles as stack pointer for exceptions and calls.
// - Program counter is 24 bits; fetch address forces bit zero low.
// - Eight-bit flags; bit 7 masks all but the non-maskable interrupt.
// - Exception sequence start sets the interrupt mask bit.
// - Bits 6 and 4 are user bits; bit 6 can mask interrupts.
// - Half-carry from bit 3, 11 or 27 by operand size.
// - Negative flag copies the result sign bit.
// - Zero flag set exactly when result is zero.
// - Overflow flag set on arithmetic overflow, cleared otherwise.
// - Carry holds carry, borrow, shifted-out bit, or bit accumulator.
// - Branch conditions use N, Z, V, C; some operations keep flags.
// - Reset loads vector into counter, sets mask and clears other flags; general registers undefined.
// - Normal mode limits addresses to 64 kbytes, advanced to 16 Mbytes.
// - One-megabyte mode uses 20 address bits and ignores the upper four.
// - Odd word or longword addresses round down without any error.
// - Decimal adjust sees two BCD digits; bit operations index bits 0 to 7.
`timescale 1ns/1ps
`default_nettype none
module crf_core
   import crf_pkg::*;
#(
   parameter int NUM_REGS = GP_COUNT
) (
   // Clock and reset.
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   // Reset vector and mode.
   input  wire logic [PC_WIDTH-1:0]   reset_vector,
   input  wire crf_amode_type         amode,
   // General register access.
   input  wire crf_gp_wr_type         gp_wr,
   input  wire logic [SEL_WIDTH-1:0]  rd_sel,
   input  wire logic                  rd_ext_half,
   input  wire crf_size_type          rd_size,
   // Stack pointer adjust.
   input  wire logic                  sp_adj_en,
   input  wire logic [GP_WIDTH-1:0]   sp_adj_value,
   // Program counter.
   input  wire logic                  pc_load,
   input  wire logic [PC_WIDTH-1:0]   pc_value,
   input  wire logic                  pc_advance,
   // Flags.
   input  wire crf_flag_upd_type      flag_upd,
   input  wire logic                  exc_start,
   // Bit and decimal operand helpers.
   input  wire logic [2:0]            bit_index,
   // Interrupt screening.
   input  wire logic                  irq_req,
   input  wire logic                  irq_uses_umask,
   input  wire logic                  nmi_req,
   // Address shaping.
   input  wire logic [GP_WIDTH-1:0]   ea_in,
   input  wire logic                  ea_wide,
   // Results.
   output logic [GP_WIDTH-1:0]        rd_data,
   output logic [GP_WIDTH-1:0]        stack_pointer,
   output logic [PC_WIDTH-1:0]        fetch_addr,
   output logic [PC_WIDTH-1:0]        ea_out,
   output logic [FLAG_WIDTH-1:0]      condition_flags,
   output logic                       irq_accept,
   output logic                       bit_value,
   output logic [7:0]                 bcd_digits
);

   logic [GP_WIDTH-1:0]   wide_gp_reg [NUM_REGS];
   logic [PC_WIDTH-1:0]   pc_reg;
   logic [FLAG_WIDTH-1:0] flags_reg;
   logic [FLAG_WIDTH-1:0] flags_next;
   logic [GP_WIDTH-1:0]   gp_next;
   logic [GP_WIDTH-1:0]   rd_next;

   function automatic logic [GP_WIDTH-1:0] read_part(input logic [GP_WIDTH-1:0] r,
                                                     input crf_size_type sz,
                                                     input logic ext);
      logic [GP_WIDTH-1:0] v;
      v = '0;
      unique case (sz)
         SZ_LONG:    v = r;
         SZ_WORD: begin
            if (ext) begin
               v = {16'h0000, r[31:16]};
            end else begin
               v = {16'h0000, r[15:0]};
            end
         end
         SZ_BYTE_HI: v = {24'h000000, r[15:8]};
         SZ_BYTE_LO: v = {24'h000000, r[7:0]};
      endcase
      return v;
   endfunction

   function automatic logic sign_of(input logic [GP_WIDTH-1:0] v,
                                    input crf_size_type        sz);
      logic s;
      s = 1'b0;
      unique case (sz)
         SZ_LONG:                s = v[31];
         SZ_WORD:                s = v[15];
         SZ_BYTE_HI, SZ_BYTE_LO: s = v[7];
      endcase
      return s;
   endfunction

   function automatic logic zero_of(input logic [GP_WIDTH-1:0] v,
                                    input crf_size_type        sz);
      logic z;
      z = 1'b0;
      unique case (sz)
         SZ_LONG:                z = (v == '0);
         SZ_WORD:                z = (v[15:0] == 16'h0000);
         SZ_BYTE_HI, SZ_BYTE_LO: z = (v[7:0] == 8'h00);
      endcase
      return z;
   endfunction

   // Merge of a partial write into the old register contents.
   always_comb begin
      gp_next = wide_gp_reg[gp_wr.sel];
      unique case (gp_wr.size)
         SZ_LONG: gp_next = gp_wr.data;
         SZ_WORD: begin
            if (gp_wr.ext_half) begin
               gp_next[31:16] = gp_wr.data[15:0];
            end else begin
               gp_next[15:0] = gp_wr.data[15:0];
            end
         end
         SZ_BYTE_HI: gp_next[15:8] = gp_wr.data[7:0];
         SZ_BYTE_LO: gp_next[7:0]  = gp_wr.data[7:0];
      endcase
   end

   // Implicit stack traffic yields to an explicit write of the same register.
   logic sp_adj_take;
   always_comb begin
      sp_adj_take = sp_adj_en;
      if (gp_wr.en && gp_wr.sel == SEL_WIDTH'(STACK_SEL)) begin
         sp_adj_take = 1'b0;
      end
   end

   // No reset here: the stack pointer is left undefined until software loads it.
   always_ff @(posedge clk_sys) begin
      if (gp_wr.en) begin
         wide_gp_reg[gp_wr.sel] <= gp_next;
      end
      if (sp_adj_take) begin
         wide_gp_reg[STACK_SEL] <= sp_adj_value;
      end
   end

   always_comb begin
      rd_next = read_part(wide_gp_reg[rd_sel], rd_size, rd_ext_half);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_data    <= '0;
         bit_value  <= 1'b0;
         bcd_digits <= 8'h00;
      end else begin
         rd_data    <= rd_next;
         bit_value  <= rd_next[bit_index];
         bcd_digits <= rd_next[7:0];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stack_pointer <= '0;
      end else begin
         stack_pointer <= wide_gp_reg[STACK_SEL];
      end
   end

   // The vector port is caught on the first edge after release, never under reset.
   logic boot_pending;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         boot_pending <= 1'b1;
      end else begin
         boot_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pc_reg <= PC_RESET;
      end else if (boot_pending) begin
         pc_reg <= reset_vector;
      end else if (pc_load) begin
         pc_reg <= pc_value;
      end else if (pc_advance) begin
         pc_reg <= {pc_reg[PC_WIDTH-1:1] + (PC_WIDTH-1)'(1), 1'b0};
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fetch_addr <= '0;
      end else begin
         fetch_addr <= {pc_reg[PC_WIDTH-1:1], 1'b0};
      end
   end

   // Flag update; half-carry comes from the adder re-run on the low slice.
   logic [28:0] half_sum;
   logic        half_c;
   always_comb begin
      half_sum = '0;
      unique case (flag_upd.size)
         SZ_LONG: half_sum = flag_upd.sub ? {1'b0, flag_upd.a[27:0]} - {1'b0, flag_upd.b[27:0]}
                                          : {1'b0, flag_upd.a[27:0]} + {1'b0, flag_upd.b[27:0]};
         SZ_WORD: half_sum = flag_upd.sub ? 29'({1'b0, flag_upd.a[11:0]} - {1'b0, flag_upd.b[11:0]}) << 16
                                          : 29'({1'b0, flag_upd.a[11:0]} + {1'b0, flag_upd.b[11:0]}) << 16;
         default: half_sum = flag_upd.sub ? 29'({1'b0, flag_upd.a[3:0]} - {1'b0, flag_upd.b[3:0]}) << 24
                                          : 29'({1'b0, flag_upd.a[3:0]} + {1'b0, flag_upd.b[3:0]}) << 24;
      endcase
      half_c = half_sum[28];
   end

   always_comb begin
      flags_next = flags_reg;
      unique case (flag_upd.op)
         FOP_NONE: flags_next = flags_reg;
         FOP_ARITH: begin
            flags_next[FLAG_HALF]  = flag_upd.has_half & half_c;
            flags_next[FLAG_NEG]   = sign_of(flag_upd.result, flag_upd.size);
            flags_next[FLAG_ZERO]  = zero_of(flag_upd.result, flag_upd.size);
            flags_next[FLAG_OVF]   = flag_upd.ovf;
            flags_next[FLAG_CARRY] = flag_upd.carry;
         end
         FOP_LOGIC: begin
            flags_next[FLAG_NEG]  = sign_of(flag_upd.result, flag_upd.size);
            flags_next[FLAG_ZERO] = zero_of(flag_upd.result, flag_upd.size);
            flags_next[FLAG_OVF]  = 1'b0;
         end
         FOP_LOAD:  flags_next = flag_upd.imm;
         FOP_AND:   flags_next = flags_reg & flag_upd.imm;
         FOP_OR:    flags_next = flags_reg | flag_upd.imm;
         FOP_XOR:   flags_next = flags_reg ^ flag_upd.imm;
         FOP_CARRY: flags_next[FLAG_CARRY] = flag_upd.carry;
      endcase
      // Exception entry sets the mask bit over any flag write in the same cycle; the other bits take the write.
      if (exc_start) begin
         flags_next[FLAG_IMASK] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flags_reg <= FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         condition_flags <= FLAGS_RESET;
      end else begin
         condition_flags <= flags_next;
      end
   end

   // Screening reads the flags as they will stand, so a mask written this cycle already blocks.
   logic irq_open;
   always_comb begin
      irq_open = ~flags_next[FLAG_IMASK];
      if (irq_uses_umask && flags_next[FLAG_UMASK]) begin
         irq_open = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_accept <= 1'b0;
      end else begin
         irq_accept <= nmi_req | (irq_req & irq_open);
      end
   end

   crf_addr_unit u_addr (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .addr_in     (ea_in),
      .amode       (amode),
      .wide_access (ea_wide),
      .addr_out    (ea_out)
   );

endmodule
`default_nettype wire

// ### crf_core_properties.sv
// Purpose: Concurrent checks on the register file and flags ports.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every crf_core instance.
`timescale 1ns/1ps
`default_nettype none
module crf_core_properties
   import crf_pkg::*;
#(
   parameter int NUM_REGS = GP_COUNT
) (
   // Clock and reset.
   input wire logic                  clk_sys,
   input wire logic                  resetn,
   // Requests.
   input wire crf_amode_type         amode,
   input wire crf_flag_upd_type      flag_upd,
   input wire logic                  exc_start,
   input wire logic                  pc_load,
   input wire logic [PC_WIDTH-1:0]   pc_value,
   input wire logic                  pc_advance,
   input wire logic                  irq_req,
   input wire logic                  nmi_req,
   input wire logic [GP_WIDTH-1:0]   ea_in,
   input wire logic                  ea_wide,
   // Results.
   input wire logic [PC_WIDTH-1:0]   fetch_addr,
   input wire logic [PC_WIDTH-1:0]   ea_out,
   input wire logic [FLAG_WIDTH-1:0] condition_flags,
   input wire logic                  irq_accept
);
   logic [PC_WIDTH-1:0] ea_exp;
   logic                res_zero;
   logic                res_neg;
   logic [GP_WIDTH-1:0] r;
   assign r = flag_upd.result;
   assign ea_exp = ea_in[PC_WIDTH-1:0] & {{23{1'b1}}, ~ea_wide}
      & (amode == AM_NORMAL ? MASK_NORMAL : amode == AM_1MB ? MASK_1MB : MASK_16MB);
   assign res_zero = flag_upd.size == SZ_LONG ? r == 32'h0
      : flag_upd.size == SZ_WORD ? r[15:0] == 16'h0 : r[7:0] == 8'h0;
   assign res_neg = flag_upd.size == SZ_LONG ? r[31] : flag_upd.size == SZ_WORD ? r[15] : r[7];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   reset_flags_a: assert property ($rose(resetn) |-> condition_flags == FLAGS_RESET)
      else $error("Flags not at reset value after reset.");
   exc_mask_a: assert property (exc_start |=> condition_flags[FLAG_IMASK])
      else $error("Exception start left the mask clear.");
   arith_zero_a: assert property (flag_upd.op == FOP_ARITH && !exc_start
      |=> condition_flags[FLAG_ZERO] == $past(res_zero))
      else $error("Zero flag wrong.");
   arith_neg_a: assert property (flag_upd.op == FOP_ARITH && !exc_start
      |=> condition_flags[FLAG_NEG] == $past(res_neg))
      else $error("Negative flag wrong.");
   arith_ovf_a: assert property (flag_upd.op == FOP_ARITH
      |=> condition_flags[FLAG_OVF] == $past(flag_upd.ovf))
      else $error("Overflow flag wrong.");
   arith_carry_a: assert property (flag_upd.op == FOP_ARITH
      |=> condition_flags[FLAG_CARRY] == $past(flag_upd.carry))
      else $error("Carry flag wrong.");
   flags_hold_a: assert property (flag_upd.op == FOP_NONE && !exc_start |=> $stable(condition_flags))
      else $error("Flags moved without an update.");
   load_flags_a: assert property (flag_upd.op == FOP_LOAD && !exc_start
      |=> condition_flags == $past(flag_upd.imm))
      else $error("Flag load wrong.");
   nmi_accept_a: assert property (nmi_req |=> irq_accept)
      else $error("Non-maskable request not accepted.");
   irq_masked_a: assert property (irq_req && !nmi_req && condition_flags[FLAG_IMASK]
      && flag_upd.op == FOP_NONE && !exc_start |=> !irq_accept)
      else $error("Masked request accepted.");
   ea_shape_a: assert property (1'b1 |=> ea_out == $past(ea_exp))
      else $error("Effective address shaping wrong.");
   fetch_even_a: assert property (pc_load && amode == AM_16MB ##1 !pc_load && !pc_advance
      |=> fetch_addr == ($past(pc_value, 2) & 24'hfffffe))
      else $error("Fetch address wrong after load.");
   cover property (exc_start);
   cover property (nmi_req ##1 irq_accept);
   cover property (flag_upd.op == FOP_ARITH ##1 condition_flags[FLAG_HALF]);
endmodule
bind crf_core crf_core_properties #(.NUM_REGS(NUM_REGS)) u_props (.clk_sys, .resetn, .amode, .flag_upd,
   .exc_start, .pc_load, .pc_value, .pc_advance, .irq_req, .nmi_req, .ea_in, .ea_wide, .fetch_addr, .ea_out,
   .condition_flags, .irq_accept);
`default_nettype wire

// ### crf_alu_model.sv
// Purpose: Behavioural arithmetic unit that feeds flag updates.
// Assumes: Combinational, sized by the operand size.
// Notes:   Logic and load ops pass operand a through as result and immediate.
`timescale 1ns/1ps
`default_nettype none
module crf_alu_model
   import crf_pkg::*;
(
   // Operation request.
   input  wire crf_fop_type    op,
   input  wire crf_size_type   size,
   input  wire logic [31:0]    a,
   input  wire logic [31:0]    b,
   input  wire logic           sub,
   // Flag update.
   output crf_flag_upd_type    upd
);
   logic [31:0] m;
   logic [31:0] res;
   logic        cy;
   logic        sa;
   logic        sb;
   logic        sr;
   always_comb begin
      m = size == SZ_LONG ? 32'hffffffff : size == SZ_WORD ? 32'h0000ffff : 32'h000000ff;
      res = (op == FOP_ARITH ? (sub ? a - b : a + b) : a) & m;
      cy = sub ? (a & m) < (b & m) : ({1'b0, a & m} + {1'b0, b & m}) > {1'b0, m};
      sa = |(a & m & ~(m >> 1));
      sb = |(b & m & ~(m >> 1));
      sr = |(res & ~(m >> 1));
      // Only the operation class is passed on, so the half-carry itself is left to the flags logic.
      upd = '{op, size, a, b, res, sub, op == FOP_ARITH,
              (sub ? sa != sb : sa == sb) && sr != sa, cy, a[7:0]};
   end
endmodule
`default_nettype wire

// ### test_cpu_register_file_and_flags.sv
// Purpose: Self-checking bench for the register file and flags block.
// Assumes: Inputs change on the falling edge of clk_sys.
// Notes:   Flag cases and address-mode cases run from tables; the rest is written out by hand.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_register_file_and_flags
   import crf_pkg::*;
;
   typedef struct packed {
      crf_fop_type  op;
      crf_size_type sz;
      logic [31:0]  a;
      logic [31:0]  b;
      logic         sub;
      logic [7:0]   exp;
   } crf_row_type;
   crf_row_type rows [12] = '{
      '{FOP_ARITH, SZ_BYTE_LO, 32'h1, 32'h1, 1'b0, 8'h80}, '{FOP_ARITH, SZ_BYTE_LO, 32'hf, 32'h1, 1'b0, 8'ha0},
      '{FOP_ARITH, SZ_WORD, 32'hffff, 32'h1, 1'b0, 8'ha5}, '{FOP_ARITH, SZ_LONG, 32'h7fffffff, 32'h1, 1'b0, 8'haa},
      '{FOP_ARITH, SZ_BYTE_LO, 32'h0, 32'h1, 1'b1, 8'ha9}, '{FOP_LOGIC, SZ_BYTE_LO, 32'h0, 32'h0, 1'b0, 8'ha5},
      '{FOP_LOAD, SZ_BYTE_LO, 32'h55, 32'h0, 1'b0, 8'h55}, '{FOP_AND, SZ_BYTE_LO, 32'hf0, 32'h0, 1'b0, 8'h50},
      '{FOP_OR, SZ_BYTE_LO, 32'h0a, 32'h0, 1'b0, 8'h5a}, '{FOP_XOR, SZ_BYTE_LO, 32'hff, 32'h0, 1'b0, 8'ha5},
      '{FOP_CARRY, SZ_BYTE_LO, 32'h0, 32'h0, 1'b0, 8'ha4}, '{FOP_NONE, SZ_BYTE_LO, 32'h0, 32'h0, 1'b0, 8'ha4}};
   logic [23:0]      eexp [4] = '{24'h005679, 24'h045678, 24'h345679, 24'h345678};
   logic             clk_sys, resetn, rd_ext_half, sp_adj_en, pc_load, pc_advance, exc_start, irq_req;
   logic             irq_uses_umask, nmi_req, ea_wide, irq_accept, bit_value, alu_sub;
   logic [2:0]       rd_sel, bit_index;
   logic [7:0]       condition_flags, bcd_digits;
   logic [23:0]      reset_vector, pc_value, fetch_addr, ea_out;
   logic [31:0]      sp_adj_value, ea_in, rd_data, stack_pointer, alu_a, alu_b;
   crf_amode_type    amode;
   crf_size_type     rd_size, alu_size;
   crf_fop_type      alu_op;
   crf_gp_wr_type    gp_wr;
   crf_flag_upd_type flag_upd;
   int               errors = 0;
   int               samples_checked = 0;
   crf_core #(.NUM_REGS(GP_COUNT)) dut (.clk_sys, .resetn, .reset_vector, .amode, .gp_wr, .rd_sel, .rd_ext_half,
      .rd_size, .sp_adj_en, .sp_adj_value, .pc_load, .pc_value, .pc_advance, .flag_upd, .exc_start, .bit_index,
      .irq_req, .irq_uses_umask, .nmi_req, .ea_in, .ea_wide, .rd_data, .stack_pointer, .fetch_addr, .ea_out,
      .condition_flags, .irq_accept, .bit_value, .bcd_digits);
   crf_alu_model u_alu (.op(alu_op), .size(alu_size), .a(alu_a), .b(alu_b), .sub(alu_sub), .upd(flag_upd));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic e, input crf_size_type z, input logic [31:0] d);
      gp_wr = '{1'b1, s, e, z, d};
      step(1);
   endtask
   task automatic rd(input logic [2:0] s, input logic e, input crf_size_type z, input logic [31:0] x);
      gp_wr.en = 1'b0;
      rd_sel = s;
      rd_ext_half = e;
      rd_size = z;
      step(1);
      chk(rd_data, x);
   endtask
   task automatic finish_test;
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clk_sys);
      errors++;
      finish_test();
   end
   initial begin
      resetn = 1'b0;
      reset_vector = 24'h123457;
      amode = AM_16MB;
      gp_wr = '0;
      {rd_sel, rd_ext_half, bit_index, sp_adj_en, pc_load, pc_advance, exc_start} = '0;
      {irq_req, irq_uses_umask, nmi_req, ea_wide, alu_sub, sp_adj_value, ea_in, alu_a, alu_b, pc_value} = '0;
      rd_size = SZ_LONG;
      alu_size = SZ_BYTE_LO;
      alu_op = FOP_NONE;
      step(12);
      chk(condition_flags, 8'h80);
      resetn = 1'b1;
      step(2);
      chk(fetch_addr, 24'h123456);
      // The stack is set by a long move before anything else uses it.
      wr(3'd7, 1'b0, SZ_LONG, 32'h00fffe00);
      gp_wr.en = 1'b0;
      step(1);
      chk(stack_pointer, 32'h00fffe00);
      sp_adj_en = 1'b1;
      sp_adj_value = 32'h00fffdfc;
      step(2);
      chk(stack_pointer, 32'h00fffdfc);
      wr(3'd7, 1'b0, SZ_LONG, 32'h00fff000);
      gp_wr.en = 1'b0;
      sp_adj_en = 1'b0;
      step(1);
      chk(stack_pointer, 32'h00fff000);
      for (int i = 0; i < 8; i++) wr(i[2:0], 1'b0, SZ_LONG, 32'h01010101 * i);
      for (int i = 0; i < 8; i++) rd(i[2:0], 1'b0, SZ_LONG, 32'h01010101 * i);
      wr(3'd2, 1'b0, SZ_BYTE_HI, 32'h000000aa);
      wr(3'd2, 1'b0, SZ_BYTE_LO, 32'h000000bb);
      wr(3'd2, 1'b1, SZ_WORD, 32'h00005566);
      bit_index = 3'd3;
      rd(3'd2, 1'b0, SZ_LONG, 32'h5566aabb);
      rd(3'd2, 1'b1, SZ_WORD, 32'h00005566);
      rd(3'd2, 1'b0, SZ_WORD, 32'h0000aabb);
      rd(3'd2, 1'b0, SZ_BYTE_HI, 32'h000000aa);
      rd(3'd2, 1'b0, SZ_BYTE_LO, 32'h000000bb);
      chk(bit_value, 1'b1);
      chk(bcd_digits, 8'hbb);
      bit_index = 3'd2;
      rd(3'd3, 1'b0, SZ_LONG, 32'h03030303);
      chk(bit_value, 1'b0);
      chk(bcd_digits, 8'h03);
      foreach (rows[i]) begin
         alu_op = rows[i].op;
         alu_size = rows[i].sz;
         alu_a = rows[i].a;
         alu_b = rows[i].b;
         alu_sub = rows[i].sub;
         step(1);
         chk(condition_flags, rows[i].exp);
      end
      alu_op = FOP_LOAD;
      exc_start = 1'b1;
      step(1);
      exc_start = 1'b0;
      alu_op = FOP_NONE;
      chk(condition_flags, 8'h80);
      irq_req = 1'b1;
      step(1);
      chk(irq_accept, 1'b0);
      nmi_req = 1'b1;
      step(1);
      nmi_req = 1'b0;
      chk(irq_accept, 1'b1);
      alu_op = FOP_LOAD;
      irq_uses_umask = 1'b1;
      alu_a = 32'h40;
      step(1);
      chk(irq_accept, 1'b0);
      alu_a = 32'h0;
      step(1);
      alu_op = FOP_NONE;
      chk(irq_accept, 1'b1);
      for (int m = 0; m < 4; m++) begin
         amode = crf_amode_type'(m);
         ea_wide = m[0];
         ea_in = 32'h12345679;
         step(1);
         chk(ea_out, eexp[m]);
      end
      amode = AM_16MB;
      pc_value = 24'h000101;
      pc_load = 1'b1;
      step(1);
      pc_load = 1'b0;
      step(1);
      chk(fetch_addr, 24'h000100);
      pc_advance = 1'b1;
      step(1);
      pc_advance = 1'b0;
      step(1);
      chk(fetch_addr, 24'h000102);
      resetn = 1'b0;
      step(2);
      chk(condition_flags, 8'h80);
      resetn = 1'b1;
      step(2);
      chk(fetch_addr, 24'h123456);
      rd(3'd3, 1'b0, SZ_LONG, 32'h03030303);
      finish_test();
   end
endmodule
`default_nettype wire
